// [rtl/qdsl_defs.svh]
// qdsl_defs.svh: constants for the quad converter serial load control
// assumes inclusion by every qdsl source file that needs word layout or pin order
`ifndef QDSL_DEFS_SVH
`define QDSL_DEFS_SVH

`define QDSL_WORD_BITS   12
`define QDSL_CNT_BITS    4
`define QDSL_CNT_ZERO    4'h0
`define QDSL_CNT_ONE     4'h1
`define QDSL_CNT_LAST    4'hB
`define QDSL_CODE_BITS   8
`define QDSL_NCHAN       4

// word layout, bit 11 is the first bit shifted in
`define QDSL_KIND_POS    11
`define QDSL_SEL_HI      10
`define QDSL_SEL_LO      9
`define QDSL_DRNG_POS    8
`define QDSL_CODE_HI     7
`define QDSL_MODE_POS    9
`define QDSL_CRNG_LSB    5
`define QDSL_SI_LSB      1
`define QDSL_ACT_POS     0

// reset values
`define QDSL_CODE_RST    8'h00
`define QDSL_RNG_RST     4'hF
`define QDSL_SI_RST      4'h0
`define QDSL_WORD_ZERO   12'h000

// pin order at the synchroniser
`define QDSL_NPINS       4
`define QDSL_PIN_CLK     0
`define QDSL_PIN_DATA    1
`define QDSL_PIN_EN      2
`define QDSL_PIN_GLOBAL_HW_ACTIVATE   3
`define QDSL_SYNC_RST    4'h0

`endif

// [rtl/qdsl_pkg.sv]
// qdsl_pkg: types shared by the serial load control modules
// assumes qdsl_defs.svh is on the include path
`include "qdsl_defs.svh"
package qdsl_pkg;
	typedef logic [`QDSL_CODE_BITS-1:0] qdsl_code_t;
	typedef logic [`QDSL_WORD_BITS-1:0] qdsl_word_t;
	typedef enum logic [0:0] {
		QDSL_WORD_DATA = 1'h0,
		QDSL_WORD_CTRL = 1'h1
	} qdsl_kind_e;
endpackage : qdsl_pkg

// [rtl/qdsl_pins_if.sv]
// qdsl_pins_if: filtered pin levels and falling-edge pulses
// assumes one producer (synchroniser) and one consumer on i_mclk
`timescale 1ns/100ps
`default_nettype none
`include "qdsl_defs.svh"
interface qdsl_pins_if;
	logic [`QDSL_NPINS-1:0] level;
	logic [`QDSL_NPINS-1:0] fall;
	modport src (output level, output fall);
	modport dst (input level, input fall);
endinterface : qdsl_pins_if
`default_nettype wire

// [rtl/qdsl_sync.sv]
// qdsl_sync: three-stage synchroniser and falling-edge finder for the serial pins
// assumes pins are asynchronous to i_mclk; a level counts once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
`include "qdsl_defs.svh"
module qdsl_sync (
	input  wire logic                    i_mclk,
	input  wire logic                    i_reset_n,
	input  wire logic [`QDSL_NPINS-1:0]  i_pins,
	qdsl_pins_if.src                     o_pins
);
	logic [`QDSL_NPINS-1:0] stage1;
	logic [`QDSL_NPINS-1:0] stage2;
	logic [`QDSL_NPINS-1:0] stage3;
	logic [`QDSL_NPINS-1:0] level;
	logic [`QDSL_NPINS-1:0] fall;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stage1 <= `QDSL_SYNC_RST;
			stage2 <= `QDSL_SYNC_RST;
			stage3 <= `QDSL_SYNC_RST;
		end else begin
			stage1 <= i_pins;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `QDSL_NPINS; g++) begin : g_pin
			always_ff @(posedge i_mclk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					level[g] <= 1'b0;
					fall[g]  <= 1'b0;
				end else begin
					// accepted level moves only when the later stages agree
					if (stage2[g] == stage3[g]) begin
						level[g] <= stage2[g];
					end
					fall[g] <= level[g] & (stage2[g] == stage3[g]) & ~stage2[g];
				end
			end
		end
	endgenerate

	assign o_pins.level = level;
	assign o_pins.fall  = fall;
endmodule : qdsl_sync
`default_nettype wire

// [rtl/qdsl_top.sv]
// qdsl_top: serial load and update logic of a four-channel 8-bit converter
// assumes serial clock, data, enable and activate pins arrive asynchronously to i_mclk
// Functional notes
// - data bit is taken at each falling edge of the serial clock
// - channel word holds eight data, two select and one range bit
// - each channel code is 8 bits; range bit doubles output gain
// - every held channel code is zero after reset
// - bits shift only while enable is high; otherwise edges ignored
// - mode bit 1 means single-buffered, 0 means double-buffered
// - single-buffered outputs update on the twelfth falling clock edge
// - twelve zero bits resynchronise the word boundary
// - control word setting mode latches all pending channel data
// - once set, the mode bit cannot be cleared until reset
// - double-buffered is default; outputs update only on enable fall
// - repeated words to one channel replace the pending value
// - enable falling ends transfer and latches all pending values
// - double-buffered range changes reach outputs at enable fall
// - select 00,01,10,11 picks channel a,b,c,d
// - control word holds mode, four range, four inhibit, activate bits
// - channel active when inhibit set, or activate and hardware activate
// - reset gives mode 0, ranges 1, inhibits 0, activate 0
`timescale 1ns/100ps
`default_nettype none
`include "qdsl_defs.svh"
module qdsl_top (
	input  wire logic                        i_mclk,
	input  wire logic                        i_reset_n,
	input  wire logic                        i_serial_clk,
	input  wire logic                        i_serial_data,
	input  wire logic                        i_input_enable,
	input  wire logic                        i_global_hw_activate,
	output logic     [`QDSL_CODE_BITS-1:0]   o_output_channel_a,
	output logic     [`QDSL_CODE_BITS-1:0]   o_output_channel_b,
	output logic     [`QDSL_CODE_BITS-1:0]   o_output_channel_c,
	output logic     [`QDSL_CODE_BITS-1:0]   o_output_channel_d,
	output logic     [`QDSL_NCHAN-1:0]       o_range_select_bit,
	output logic     [`QDSL_NCHAN-1:0]       o_channel_active,
	output logic                             o_mode_single
);
	qdsl_pins_if pins ();

	qdsl_sync u_sync (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_pins    ({i_global_hw_activate, i_input_enable, i_serial_data, i_serial_clk}),
		.o_pins    (pins.src)
	);

	function automatic logic chan_hit(input logic [1:0] sel, input int idx);
		chan_hit = (sel == idx[1:0]);
	endfunction : chan_hit

	qdsl_pkg::qdsl_word_t                shift;
	logic [`QDSL_CNT_BITS-1:0]           bit_cnt;
	logic                                mode;
	logic [`QDSL_NCHAN-1:0]              shutdown_inhibit;
	logic                                sw_activate;
	qdsl_pkg::qdsl_code_t                pend_code [`QDSL_NCHAN];
	logic [`QDSL_NCHAN-1:0]              pend_range;
	qdsl_pkg::qdsl_code_t                out_code [`QDSL_NCHAN];
	logic [`QDSL_NCHAN-1:0]              out_range;

	logic                                en_lvl;
	logic                                en_fall;
	logic                                accept;
	qdsl_pkg::qdsl_word_t                next_shift;
	logic                                resync;
	logic                                word_done;
	qdsl_pkg::qdsl_kind_e                kind;
	logic                                ctrl_done;
	logic                                data_done;
	logic                                next_mode;
	logic                                update;
	qdsl_pkg::qdsl_code_t                next_pend_code [`QDSL_NCHAN];
	logic [`QDSL_NCHAN-1:0]              next_pend_range;

	assign en_lvl     = pins.level[`QDSL_PIN_EN];
	assign en_fall    = pins.fall[`QDSL_PIN_EN];
	assign accept     = pins.fall[`QDSL_PIN_CLK] & en_lvl;
	assign next_shift = {shift[`QDSL_WORD_BITS-2:0], pins.level[`QDSL_PIN_DATA]};
	// only the twelfth zero in a row marks a boundary; later zeros count as word bits
	assign resync     = accept & (next_shift == `QDSL_WORD_ZERO) &
		(shift != `QDSL_WORD_ZERO);
	assign word_done  = accept & ~resync & (bit_cnt == `QDSL_CNT_LAST);
	assign kind       = qdsl_pkg::qdsl_kind_e'(next_shift[`QDSL_KIND_POS]);
	assign ctrl_done  = word_done & (kind == qdsl_pkg::QDSL_WORD_CTRL);
	assign data_done  = word_done & (kind == qdsl_pkg::QDSL_WORD_DATA);
	// mode can only be set, never cleared
	assign next_mode  = mode | (ctrl_done & next_shift[`QDSL_MODE_POS]);
	// single-buffered updates at word end, any mode at enable fall
	assign update     = en_fall | (word_done & next_mode);

	// word framing: twelve-bit shift register and bit counter
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			shift   <= `QDSL_WORD_ZERO;
			bit_cnt <= `QDSL_CNT_ZERO;
		end else if (en_fall) begin
			bit_cnt <= `QDSL_CNT_ZERO;
		end else if (accept) begin
			shift <= next_shift;
			if (resync || word_done) begin
				bit_cnt <= `QDSL_CNT_ZERO;
			end else begin
				bit_cnt <= bit_cnt + `QDSL_CNT_ONE;
			end
		end
	end

	// control settings
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mode             <= 1'b0;
			shutdown_inhibit <= `QDSL_SI_RST;
			sw_activate      <= 1'b0;
		end else begin
			mode <= next_mode;
			if (ctrl_done) begin
				shutdown_inhibit <= next_shift[`QDSL_SI_LSB +: `QDSL_NCHAN];
				sw_activate      <= next_shift[`QDSL_ACT_POS];
			end
		end
	end

	// pending values and output latches per channel
	genvar c;
	generate
		for (c = 0; c < `QDSL_NCHAN; c++) begin : g_chan
			always_comb begin
				next_pend_code[c]  = pend_code[c];
				next_pend_range[c] = pend_range[c];
				if (data_done && chan_hit(next_shift[`QDSL_SEL_HI:`QDSL_SEL_LO], c)) begin
					next_pend_code[c]  = next_shift[`QDSL_CODE_HI:0];
					next_pend_range[c] = next_shift[`QDSL_DRNG_POS];
				end else if (ctrl_done) begin
					next_pend_range[c] = next_shift[`QDSL_CRNG_LSB + c];
				end
			end

			always_ff @(posedge i_mclk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					pend_code[c]  <= `QDSL_CODE_RST;
					pend_range[c] <= 1'b1;
				end else begin
					pend_code[c]  <= next_pend_code[c];
					pend_range[c] <= next_pend_range[c];
				end
			end

			always_ff @(posedge i_mclk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					out_code[c]  <= `QDSL_CODE_RST;
					out_range[c] <= 1'b1;
				end else if (update) begin
					out_code[c]  <= next_pend_code[c];
					out_range[c] <= next_pend_range[c];
				end
			end

			always_ff @(posedge i_mclk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					o_channel_active[c] <= 1'b0;
				end else begin
					o_channel_active[c] <= shutdown_inhibit[c] |
						(sw_activate & pins.level[`QDSL_PIN_GLOBAL_HW_ACTIVATE]);
				end
			end
		end
	endgenerate

	assign o_output_channel_a = out_code[0];
	assign o_output_channel_b = out_code[1];
	assign o_output_channel_c = out_code[2];
	assign o_output_channel_d = out_code[3];
	assign o_range_select_bit = out_range;
	assign o_mode_single      = mode;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	chk_enable_gating: assert property (
		(!en_lvl && !en_fall) |=> $stable(bit_cnt) && $stable(shift))
		else $error("serial bits taken while enable low");
	chk_mode_sticky: assert property (mode |=> mode)
		else $error("mode bit cleared after being set");
	chk_double_hold: assert property (
		(!mode && !en_fall && !ctrl_done) |=> $stable(o_output_channel_a) && $stable(o_output_channel_d))
		else $error("double-buffered output moved without enable fall");
	chk_range_hold: assert property (
		(!mode && !en_fall && !ctrl_done) |=> $stable(o_range_select_bit))
		else $error("double-buffered range moved without enable fall");
	chk_enable_latch: assert property (
		en_fall |=> (o_output_channel_b == pend_code[1]) && (o_range_select_bit == pend_range))
		else $error("enable fall did not latch pending values");
	chk_single_update: assert property (
		(word_done && next_mode) |=> (o_output_channel_c == pend_code[2]) &&
			(bit_cnt == `QDSL_CNT_ZERO))
		else $error("single-buffered word end did not update outputs");
	chk_word_length: assert property (
		word_done |-> accept && (bit_cnt == `QDSL_CNT_LAST) && $past(bit_cnt) != `QDSL_CNT_ZERO)
		else $error("word completed at wrong bit count");
	chk_resync_zero: assert property (resync |=> bit_cnt == 4'h0 && !$past(word_done))
		else $error("twelve zeros did not resynchronise");
	chk_active_map: assert property (
		##1 o_channel_active == $past(shutdown_inhibit |
			{4{sw_activate & pins.level[`QDSL_PIN_GLOBAL_HW_ACTIVATE]}}))
		else $error("channel activity does not follow inhibit and activate");
	chk_ctrl_range: assert property (
		ctrl_done |=> pend_range == $past(next_shift[`QDSL_CRNG_LSB +: `QDSL_NCHAN]))
		else $error("control word did not load all pending ranges");
	chk_select_a: assert property (
		(data_done && chan_hit(next_shift[`QDSL_SEL_HI:`QDSL_SEL_LO], 0)) |=>
			pend_code[0] == $past(next_shift[`QDSL_CODE_HI:0]))
		else $error("select code zero did not write channel a");

	cov_enable_latch: cover property (en_fall && !mode);
	cov_mode_set: cover property (!mode ##1 mode);
	cov_resync: cover property (resync);
	cov_single_word: cover property (word_done && mode);
	cov_data_word: cover property (data_done && !mode ##[1:1000] en_fall);
endmodule : qdsl_top
`default_nettype wire

// [test/qdsl_host_model.sv]
// qdsl_host_model: controller side of the three-wire serial link
// assumes the bench clock i_mclk; all pins change at its falling edge
`timescale 1ns/100ps
`default_nettype none
module qdsl_host_model (
	input  wire logic i_mclk,
	output logic      o_sclk,
	output logic      o_sdata,
	output logic      o_en
);
	initial begin
		o_sclk = 1'h0;
		o_sdata = 1'h1;
		o_en = 1'h0;
	end
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge i_mclk);
	endtask : wait_cyc
	// 160 ns serial period; data held 60 ns past the fall, then scrambled
	task automatic send_bit(input logic b);
		o_sdata = b;
		o_sclk = 1'h1;
		wait_cyc(16);
		o_sclk = 1'h0;
		wait_cyc(12);
		o_sdata = ~b;
		wait_cyc(4);
	endtask : send_bit
	task automatic send_word(input logic [11:0] w);
		for (int i = 11; i >= 0; i--) begin
			send_bit(w[i]);
		end
	endtask : send_word
	// each device has its own enable; the strobe is spaced from clock falls
	task automatic set_en(input logic v);
		o_en = v;
		wait_cyc(32);
	endtask : set_en
endmodule : qdsl_host_model
`default_nettype wire

// [test/tb.sv]
// tb: self-checking bench for the quad converter serial load control
// assumes qdsl_top and qdsl_host_model; pins driven at falling mclk edges
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic       i_mclk;
	logic       i_reset_n;
	logic       hw;
	logic       sclk;
	logic       sdata;
	logic       en;
	logic [7:0] ch_a;
	logic [7:0] ch_b;
	logic [7:0] ch_c;
	logic [7:0] ch_d;
	logic [3:0] range_select_bit;
	logic [3:0] act;
	logic       mode;
	int         mismatches;
	int         n_tests;
	initial i_mclk = 1'h0;
	always #2.5 i_mclk = ~i_mclk;
	qdsl_top u_qdsl_top (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_serial_clk(sclk),
		.i_serial_data(sdata), .i_input_enable(en), .i_global_hw_activate(hw),
		.o_output_channel_a(ch_a), .o_output_channel_b(ch_b), .o_output_channel_c(ch_c),
		.o_output_channel_d(ch_d), .o_range_select_bit(range_select_bit), .o_channel_active(act),
		.o_mode_single(mode));
	qdsl_host_model u_qdsl_host_model (.i_mclk(i_mclk), .o_sclk(sclk), .o_sdata(sdata),
		.o_en(en));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic outs(input logic [7:0] a, b, c, d, input logic [3:0] r);
		check("channel a", ch_a, a);
		check("channel b", ch_b, b);
		check("channel c", ch_c, c);
		check("channel d", ch_d, d);
		check("ranges", {4'h0, range_select_bit}, {4'h0, r});
	endtask : outs
	task automatic conclude();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	task automatic put_en(input logic v);
		u_qdsl_host_model.set_en(v);
	endtask : put_en
	task automatic put_word(input logic [11:0] w);
		u_qdsl_host_model.send_word(w);
	endtask : put_word
	task automatic set_hw(input logic v);
		hw = v;
		repeat (10) @(negedge i_mclk);
	endtask : set_hw
	task automatic t_reset();
		outs(8'h00, 8'h00, 8'h00, 8'h00, 4'hF);
		check("active", {4'h0, act}, 8'h00);
		check("mode", {7'h00, mode}, 8'h00);
	endtask : t_reset
	task automatic t_double();
		put_en(1'h1);
		put_word(12'h05A);
		put_word(12'h3C3);
		put_word(12'h411);
		put_word(12'h7FF);
		put_word(12'h024);
		outs(8'h00, 8'h00, 8'h00, 8'h00, 4'hF);
		put_en(1'h0);
		outs(8'h24, 8'hC3, 8'h11, 8'hFF, 4'hA);
		put_word(12'h0AA);
		put_en(1'h1);
		put_en(1'h0);
		outs(8'h24, 8'hC3, 8'h11, 8'hFF, 4'hA);
	endtask : t_double
	task automatic t_ctrl();
		put_en(1'h1);
		put_word(12'h8A5);
		check("ranges held", {4'h0, range_select_bit}, 8'h0A);
		check("active hw low", {4'h0, act}, 8'h02);
		set_hw(1'h1);
		check("active hw high", {4'h0, act}, 8'h0F);
		set_hw(1'h0);
		put_en(1'h0);
		outs(8'h24, 8'hC3, 8'h11, 8'hFF, 4'h5);
	endtask : t_ctrl
	task automatic t_resync();
		logic [4:0] junk;
		// junk ends in a one so the zero run starts with the zero word and resyncs at its twelfth bit
		junk = 5'h01;
		put_en(1'h1);
		for (int i = 4; i >= 0; i--) begin
			u_qdsl_host_model.send_bit(junk[i]);
		end
		put_word(12'h000);
		put_word(12'h0E7);
		put_en(1'h0);
		outs(8'hE7, 8'hC3, 8'h11, 8'hFF, 4'h4);
	endtask : t_resync
	task automatic t_single();
		put_en(1'h1);
		put_word(12'h266);
		put_word(12'hBE0);
		check("mode set", {7'h00, mode}, 8'h01);
		outs(8'hE7, 8'h66, 8'h11, 8'hFF, 4'hF);
		put_word(12'h59C);
		outs(8'hE7, 8'h66, 8'h9C, 8'hFF, 4'hF);
		put_word(12'h8E0);
		check("mode sticky", {7'h00, mode}, 8'h01);
		outs(8'hE7, 8'h66, 8'h9C, 8'hFF, 4'h7);
		put_word(12'h700);
		outs(8'hE7, 8'h66, 8'h9C, 8'h00, 4'hF);
	endtask : t_single
	initial begin
		hw = 1'h0;
		i_reset_n = 1'h0;
		repeat (4) @(negedge i_mclk);
		i_reset_n = 1'h1;
		repeat (8) @(negedge i_mclk);
		t_reset();
		t_double();
		t_ctrl();
		t_resync();
		t_single();
		conclude();
	end
	initial begin
		#200000;
		mismatches++;
		conclude();
	end
endmodule : tb
`default_nettype wire
